// *** hdl/smr_pkg.sv ***
// Purpose: Constants and types for the serial master with rate select.
// Assumes: APB slave, 32-bit words, one clock at 40 MHz.
// Notes: Pin vectors index slave select, input data, output data, clock.
//
// Operation
// R01 - Master select bit makes device link master.
// R02 - Only a master starts any transfer.
// R03 - Transmit data write begins a new transfer.
// R04 - Idle shifter loads at once, sets empty flag.
// R05 - Byte shifts out on output data pin.
// R06 - Rate bits pick divisor 2, 8, 32, 128.
// R07 - Serial clock equals base clock over twice divisor.
// R08 - Rate bits ignored while configured as slave.
// R09 - Reset clears both rate select bits.
// R10 - Software sets role before enabling interface.
// R11 - Enable master interface before slave interface.
// R12 - Disable slave interface before master interface.
// R13 - Disabled interface returns its pins to port use.
// R14 - Slave select pin free when disabled or master.
// R15 - Port direction never overrides owned pins.
// R16 - Eight serial clocks per byte, full duplex.
// R17 - Write while busy clears the empty flag.

package smr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_TXDATA   = 8'h04;
	localparam logic [7:0] ADDR_RXDATA   = 8'h08;
	localparam logic [7:0] ADDR_STATUS   = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_PORT_DIR = 8'h18;
	localparam logic [7:0] ADDR_PORT_OUT = 8'h1c;
	localparam logic [7:0] ADDR_PORT_IN  = 8'h20;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int         BYTE_W      = 8;
	localparam int         NPINS       = 4;
	localparam int         PIN_SS      = 0;
	localparam int         PIN_MISO    = 1;
	localparam int         PIN_MOSI    = 2;
	localparam int         PIN_SCK     = 3;
	localparam int         IRQ_W       = 2;
	localparam int         IRQ_TXE     = 0;
	localparam int         IRQ_DONE    = 1;
	localparam logic [3:0] CTRL_RESET  = 4'h0;
	localparam logic [3:0] LAST_HALF   = 4'hf;
	localparam logic [7:0] DIV_SEL0    = 8'h02;
	localparam logic [7:0] DIV_SEL1    = 8'h08;
	localparam logic [7:0] DIV_SEL2    = 8'h20;
	localparam logic [7:0] DIV_SEL3    = 8'h80;

	typedef struct packed {
		logic rate_select_high;
		logic rate_select_low;
		logic master_select_bit;
		logic interface_enable_bit;
	} smr_ctrl_type;

	typedef struct packed {
		logic [NPINS-1:0] o;
		logic [NPINS-1:0] oe;
	} smr_pins_type;

	// Half of a serial clock period lasts this many base clock cycles.
	function automatic logic [7:0] smr_divisor(input logic [1:0] sel);
		case (sel)
			2'b00:   smr_divisor = DIV_SEL0;
			2'b01:   smr_divisor = DIV_SEL1;
			2'b10:   smr_divisor = DIV_SEL2;
			default: smr_divisor = DIV_SEL3;
		endcase
	endfunction

endpackage

// *** hdl/smr_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter for pins.
// Assumes: Inputs are asynchronous to pclk.
// Notes: A change is taken once the second and third stages agree.

`timescale 1ns/1ps

module smr_sync
	import smr_pkg::*;
#(
	parameter int W = 4
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	if (W < 1) begin : g_chk
		$error("smr_sync needs at least one bit");
	end

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] agree;
	logic [W-1:0] next_q;

	assign agree  = ~(s2 ^ s3);
	assign next_q = (agree & s2) | (~agree & q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q  <= '0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q  <= next_q;
		end
	end

endmodule

// *** hdl/smr_rate_div.sv ***
// Purpose: Half-period enable pulse for the serial clock.
// Assumes: Runs only while a master transfer is in progress.
// Notes: Restart aligns the first half period to the byte load.

`timescale 1ns/1ps

module smr_rate_div
	import smr_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       restart,
	input  wire logic       run,
	input  wire logic [1:0] sel,
	output logic            tick
);

	if (CNT_W < 8) begin : g_chk
		$error("smr_rate_div counter too narrow for largest divisor");
	end

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] limit;

	// A tick every divisor cycles gives a period of twice the divisor.
	assign limit = CNT_W'(smr_divisor(sel)) - CNT_W'(1); // R06 R07
	// Restart stays out of the tick so the done-to-reload path forms no loop.
	assign tick  = run && (cnt == limit);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (restart || !run || tick) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + CNT_W'(1);
		end
	end

endmodule

// *** hdl/smr_spi_master.sv ***
// Purpose: Serial master with four rates, APB registers and port sharing.
// Assumes: Zero-wait APB slave; base clock is pclk.
// Notes: Slave mode only presents transmit data; it does not shift.
//
// Chosen here: the placing of the registers and the APB slave port.

`timescale 1ns/1ps

module smr_spi_master
	import smr_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [NPINS-1:0] pin_in,
	output smr_pins_type          pins,
	output logic                  irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	smr_ctrl_type     ctrl;
	smr_pins_type     next_pins;
	logic [NPINS-1:0] port_dir;
	logic [NPINS-1:0] port_out;
	logic [NPINS-1:0] pin_s;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_set;
	logic [BYTE_W-1:0] txdata;
	logic [BYTE_W-1:0] shift;
	logic [BYTE_W-1:0] rxsh;
	logic [BYTE_W-1:0] rxdata;
	logic [BYTE_W-1:0] load_data;
	logic [3:0]       half;
	logic             txe_flag;
	logic             busy;
	logic             sck;
	logic             tick;
	logic             en;
	logic             master;
	logic             setup;
	logic             wr;
	logic             tx_wr;
	logic             start_now;
	logic             load_pend;
	logic             load;
	logic             done;
	logic             rise;
	logic             fall;
	logic [31:0]      rd_val;
	logic [NPINS-1:0] own;
	logic [NPINS-1:0] spi_o;
	logic [NPINS-1:0] spi_oe;

	function automatic logic addr_hit(input logic [7:0] a);
		case (a)
			ADDR_CTRL, ADDR_TXDATA, ADDR_RXDATA, ADDR_STATUS,
			ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_PORT_DIR,
			ADDR_PORT_OUT, ADDR_PORT_IN: addr_hit = 1'b1;
			default:                     addr_hit = 1'b0;
		endcase
	endfunction

	function automatic logic wr_to(input logic [7:0] a, input logic w, input logic [7:0] r);
		wr_to = w && (a == r);
	endfunction

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign setup  = psel && !penable;
	assign pready = psel && penable;
	assign wr     = psel && penable && pwrite;
	assign tx_wr  = wr_to(paddr, wr, ADDR_TXDATA);

	always_comb begin
		rd_val = '0;
		case (paddr)
			ADDR_CTRL:     rd_val[3:0] = ctrl;
			ADDR_TXDATA:   rd_val[BYTE_W-1:0] = txdata;
			ADDR_RXDATA:   rd_val[BYTE_W-1:0] = rxdata;
			ADDR_STATUS:   rd_val[1:0] = {busy, txe_flag};
			ADDR_IRQ_STAT: rd_val[IRQ_W-1:0] = irq_stat;
			ADDR_IRQ_MASK: rd_val[IRQ_W-1:0] = irq_mask;
			ADDR_PORT_DIR: rd_val[NPINS-1:0] = port_dir;
			ADDR_PORT_OUT: rd_val[NPINS-1:0] = port_out;
			// Direction picks latch or pin even for pins the link owns.
			ADDR_PORT_IN:  rd_val[NPINS-1:0] = (port_dir & port_out) | (~port_dir & pin_s); // R15
			default:       rd_val = '0;
		endcase
	end

	// Read data is caught in the setup cycle so it stands all access long.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_val;
			pslverr <= !addr_hit(paddr);
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET; // R09
		end else if (wr_to(paddr, wr, ADDR_CTRL)) begin
			ctrl <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_dir <= '0;
			port_out <= '0;
			irq_mask <= '0;
		end else begin
			if (wr_to(paddr, wr, ADDR_PORT_DIR)) port_dir <= pwdata[NPINS-1:0];
			if (wr_to(paddr, wr, ADDR_PORT_OUT)) port_out <= pwdata[NPINS-1:0];
			if (wr_to(paddr, wr, ADDR_IRQ_MASK)) irq_mask <= pwdata[IRQ_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Transfer control
	// ----------------------------------------------------------------
	assign en     = ctrl.interface_enable_bit;
	assign master = en && ctrl.master_select_bit; // R01 R02
	assign rise   = tick && !half[0];
	assign fall   = tick && half[0];
	assign done   = busy && fall && (half == LAST_HALF);
	// A write in the last edge's cycle with nothing queued starts at once.
	assign start_now = tx_wr && master && (!busy || (done && txe_flag)); // R03
	assign load_pend = done && !txe_flag && master;
	assign load      = start_now || load_pend;
	assign load_data = start_now ? pwdata[BYTE_W-1:0] : txdata;
	assign irq_set   = {done, load};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txdata <= '0;
		end else if (tx_wr) begin
			txdata <= pwdata[BYTE_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txe_flag <= 1'b1;
		end else if (start_now || !master) begin
			txe_flag <= 1'b1; // R04
		end else if (tx_wr && busy) begin
			txe_flag <= 1'b0; // R17
		end else if (load_pend) begin
			txe_flag <= 1'b1;
		end
	end

	// Dropping the master role aborts the byte so no stray clocks remain.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			half <= '0;
			sck  <= 1'b0;
		end else if (!master) begin
			busy <= 1'b0; // R02
			half <= '0;
			sck  <= 1'b0;
		end else if (load) begin
			busy <= 1'b1;
			half <= '0;
			sck  <= 1'b0;
		end else if (tick) begin
			busy <= !done;
			half <= half + 4'h1; // R16
			sck  <= !half[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift <= '0;
			rxsh  <= '0;
		end else if (load) begin
			shift <= load_data; // R04
			rxsh  <= '0;
		end else if (fall) begin
			shift <= {shift[BYTE_W-2:0], 1'b0}; // R05
			rxsh  <= {rxsh[BYTE_W-2:0], pin_s[PIN_MISO]}; // R16
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxdata <= '0;
		end else if (done) begin
			rxdata <= {rxsh[BYTE_W-2:0], pin_s[PIN_MISO]};
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	// A new event beats a clear written in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
		end else if (wr_to(paddr, wr, ADDR_IRQ_STAT)) begin
			irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat <= irq_stat | irq_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Pin sharing
	// ----------------------------------------------------------------
	assign own[PIN_SCK]  = en; // R13
	assign own[PIN_MOSI] = en;
	assign own[PIN_MISO] = en;
	assign own[PIN_SS]   = en && !ctrl.master_select_bit; // R14

	assign spi_o[PIN_SCK]   = sck; // R07
	assign spi_o[PIN_MOSI]  = shift[BYTE_W-1]; // R05
	assign spi_o[PIN_MISO]  = txdata[BYTE_W-1];
	assign spi_o[PIN_SS]    = 1'b0;
	assign spi_oe[PIN_SCK]  = master;
	assign spi_oe[PIN_MOSI] = master;
	assign spi_oe[PIN_MISO] = en && !ctrl.master_select_bit && !pin_s[PIN_SS];
	assign spi_oe[PIN_SS]   = 1'b0;

	assign next_pins.o  = (own & spi_o) | (~own & port_out);
	assign next_pins.oe = (own & spi_oe) | (~own & port_dir); // R15

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins <= '0;
		end else begin
			pins <= next_pins;
		end
	end

	// ----------------------------------------------------------------
	// Pin input synchroniser and rate divider
	// ----------------------------------------------------------------
	smr_sync #(
		.W (NPINS)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pin_in),
		.q       (pin_s)
	);

	// The divider runs only for a master byte, so the rate bits idle in slave.
	smr_rate_div #(
		.CNT_W (8)
	) u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.restart (load),
		.run     (busy),
		.sel     ({ctrl.rate_select_high, ctrl.rate_select_low}), // R08
		.tick    (tick)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [3:0] rise_cnt;
	logic [7:0] gap;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_cnt <= '0;
			gap      <= '0;
		end else begin
			rise_cnt <= load ? 4'h0 : (rise ? rise_cnt + 4'h1 : rise_cnt);
			gap      <= (load || tick) ? 8'h00 : gap + 8'h01;
		end
	end

	sequence s_idle_write;
		tx_wr && master && !busy;
	endsequence

	sequence s_loaded;
		busy && txe_flag && (shift == $past(pwdata[BYTE_W-1:0]));
	endsequence

	a_load_at_once: assert property (s_idle_write |=> s_loaded) // R04
		else $error("idle write did not load shifter");
	a_slave_no_start: assert property ($rose(busy) |-> $past(master)) // R02
		else $error("transfer started while not master");
	a_busy_write_flag: assert property (tx_wr && busy && !done |=> !txe_flag) // R17
		else $error("empty flag not cleared on busy write");
	a_eight_clocks: assert property (done |-> rise_cnt == 4'h8) // R16
		else $error("byte did not take eight serial clocks");
	a_rate_fastest: assert property (tick && busy && !done &&
		{ctrl.rate_select_high, ctrl.rate_select_low} == 2'b00 &&
		!wr |-> gap == 8'h01) // R06
		else $error("divisor two half period wrong");
	a_rate_slowest: assert property (tick && busy && !done &&
		{ctrl.rate_select_high, ctrl.rate_select_low} == 2'b11 &&
		$stable(ctrl) |-> gap == 8'h7f) // R07
		else $error("divisor 128 half period wrong");
	a_pin_release: assert property (!en |=> pins.oe == $past(port_dir)) // R13
		else $error("disabled interface kept a pin");
	a_ss_free: assert property (!(en && !ctrl.master_select_bit) |=>
		pins.oe[PIN_SS] == $past(port_dir[PIN_SS])) // R14
		else $error("slave select not released");
	a_dir_override: assert property (master |=>
		pins.oe[PIN_SCK] && pins.oe[PIN_MOSI] && !pins.oe[PIN_MISO]) // R15
		else $error("port direction overrode link pins");
	a_mosi_msb: assert property (load |=> ##1 pins.o[PIN_MOSI] == $past(load_data[BYTE_W-1], 2)) // R05
		else $error("first data bit is not the top bit");
	a_write_starts: assert property (start_now |=> busy [*2]) // R03
		else $error("transmit write did not start a transfer");

endmodule

// *** sim/smr_slave_model.sv ***
// Purpose: Behavioural serial slave on the far side of the link.
// Assumes: Clock idles low, data is taken on the rising and changed on the falling edge.
// Notes: After each eighth falling edge the data line turns to the inverse level.

`timescale 1ns/1ps

module smr_slave_model (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       load,
	input  wire logic [7:0] tx,
	output logic            miso,
	output logic      [7:0] rx,
	output logic      [4:0] nrise
);
	logic [7:0] sr;

	initial begin
		miso = 1'b0;
		rx = 8'h00;
		nrise = 5'h00;
		sr = 8'h00;
	end

	// Released data goes to the inverse level so a stale bit can never pass.
	always @(posedge sck or negedge sck or posedge load) begin
		if (load) begin
			sr    <= tx;
			miso  <= tx[7];
			nrise <= 5'h00;
		end else if (sck) begin
			rx    <= {rx[6:0], mosi};
			nrise <= nrise + 5'h01;
		end else begin
			sr   <= {sr[6:0], 1'b0};
			miso <= (nrise[2:0] == 3'h0) ? ~miso : sr[6];
		end
	end
endmodule

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the serial master with rate select.
// Assumes: Zero-wait APB slave; pins resolve from enables and far-side levels.
// Notes: Received data is judged from rate one up, where the input lag is covered.

`timescale 1ns/1ps

module tb
	import smr_pkg::*;
;
	logic         pclk;
	logic         presetn;
	logic         psel;
	logic         penable;
	logic         pwrite;
	logic [7:0]   paddr;
	logic [31:0]  pwdata;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	smr_pins_type pins;
	logic         irq;
	logic [3:0]   ext;
	logic         load;
	logic [7:0]   stx;
	logic         miso_m;
	logic [7:0]   srx;
	logic [4:0]   nrise;
	logic         last_err;
	int           n_errors;
	int           checks;
	int           cyc;
	wire  [3:0]   pad;

	assign pad = (pins.oe & pins.o) | (~pins.oe & {ext[3:2], miso_m, ext[0]});

	smr_spi_master DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pad), .pins(pins), .irq(irq));

	smr_slave_model slave (.sck(pad[PIN_SCK]), .mosi(pad[PIN_MOSI]), .load(load), .tx(stx),
		.miso(miso_m), .rx(srx), .nrise(nrise));

	always #12.5 pclk = ~pclk;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task report_and_stop;
		if (n_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// A hang costs one mismatch and ends the run.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			report_and_stop;
		end
	end

	task check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		check(r, e);
	endtask

	task wait_idle;
		logic [31:0] r;
		r = 32'h2;
		for (int i = 0; i < 3000 && r[1]; i++)
			apb(1'b0, ADDR_STATUS, 32'h0, r);
	endtask

	task till_sck(input logic v, inout int c);
		while (pins.o[PIN_SCK] !== v && c < 2000) begin
			@(negedge pclk);
			c++;
		end
	endtask

	task arm(input logic [7:0] b);
		repeat (2) @(posedge pclk);
		stx  <= b;
		load <= 1'b1;
		@(posedge pclk);
		load <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		logic [31:0] r;
		rdc(ADDR_CTRL, 32'h0);
		rdc(ADDR_STATUS, 32'h1);
		rdc(ADDR_IRQ_STAT, 32'h0);
		check({28'h0, pins.oe}, 32'h0);
		apb(1'b0, 8'h24, 32'h0, r);
		check(r, 32'h0);
		check({31'h0, last_err}, 32'h1);
	endtask

	task t_rate(input logic [1:0] r);
		int c;
		logic [7:0] b;
		b = 8'h5a ^ {r, 6'h00};
		wr(ADDR_CTRL, {28'h0, r, 2'b10});
		wr(ADDR_CTRL, {28'h0, r, 2'b11});
		arm(~b);
		wr(ADDR_TXDATA, {24'h0, b});
		rdc(ADDR_STATUS, 32'h3);
		c = 0;
		till_sck(1'b1, c);
		c = 0;
		till_sck(1'b0, c);
		till_sck(1'b1, c);
		check(32'(c), 32'h4 << (2 * r));
		wait_idle;
		check({27'h0, nrise}, 32'h8);
		check({24'h0, srx}, {24'h0, b});
		check({31'h0, pins.o[PIN_SCK]}, 32'h0);
		if (r != 2'b00)
			rdc(ADDR_RXDATA, {24'h0, ~b});
	endtask

	task t_queue;
		wr(ADDR_CTRL, 32'h7);
		wr(ADDR_IRQ_STAT, 32'h3);
		arm(8'h3c);
		wr(ADDR_TXDATA, 32'hc3);
		wr(ADDR_TXDATA, 32'h96);
		rdc(ADDR_STATUS, 32'h2);
		wait_idle;
		check({27'h0, nrise}, 32'h10);
		check({24'h0, srx}, 32'h96);
		rdc(ADDR_IRQ_STAT, 32'h3);
		check({31'h0, irq}, 32'h0);
		wr(ADDR_IRQ_MASK, 32'h2);
		repeat (2) @(negedge pclk);
		check({31'h0, irq}, 32'h1);
		wr(ADDR_IRQ_STAT, 32'h2);
		repeat (2) @(negedge pclk);
		check({31'h0, irq}, 32'h0);
		rdc(ADDR_IRQ_STAT, 32'h1);
	endtask

	task t_ports;
		logic [31:0] r;
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_PORT_DIR, 32'hf);
		wr(ADDR_PORT_OUT, 32'h5);
		repeat (2) @(negedge pclk);
		check({28'h0, pins.oe}, 32'hf);
		check({28'h0, pins.o}, 32'h5);
		rdc(ADDR_PORT_IN, 32'h5);
		wr(ADDR_CTRL, 32'h3);
		repeat (2) @(negedge pclk);
		check({28'h0, pins.oe}, 32'hd);
		check({31'h0, pins.o[PIN_SS]}, 32'h1);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_PORT_DIR, 32'h0);
		repeat (5) @(posedge pclk);
		apb(1'b0, ADDR_PORT_IN, 32'h0, r);
		check(r & 32'hd, 32'h9);
	endtask

	task t_slave;
		ext <= 4'b1000;
		wr(ADDR_CTRL, 32'hc);
		wr(ADDR_CTRL, 32'hd);
		arm(8'h11);
		wr(ADDR_TXDATA, 32'h80);
		repeat (300) @(negedge pclk);
		check({27'h0, nrise}, 32'h0);
		rdc(ADDR_STATUS, 32'h1);
		check({28'h0, pins.oe}, 32'h2);
		check({31'h0, pins.o[PIN_MISO]}, 32'h1);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext = 4'b1001;
		load = 1'b0;
		stx = 8'h00;
		n_errors = 0;
		checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		for (int r = 0; r < 4; r++)
			t_rate(2'(r));
		t_queue;
		t_ports;
		t_slave;
		report_and_stop;
	end
endmodule
